// file: iop_pkg.sv
// Shared constants for the port C/D/E and tone block
package iop_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PC_DATA   = 8'h00;
  localparam logic [7:0] OFS_PC_FLAGS  = 8'h04;
  localparam logic [7:0] OFS_PC_ENABLE = 8'h08;
  localparam logic [7:0] OFS_OPTION    = 8'h0C;
  localparam logic [7:0] OFS_PD_DATA   = 8'h10;
  localparam logic [7:0] OFS_DIR_COMB  = 8'h14;
  localparam logic [7:0] OFS_PE_DATA   = 8'h18;
  localparam logic [7:0] OFS_PE_DIR    = 8'h1C;
  localparam logic [7:0] OFS_TONE_CTRL = 8'h20;
  localparam logic [7:0] OFS_SUMMARY   = 8'h24;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int OPT_FOURTH_FLOAT = 3;
  localparam int OPT_THIRD_FLOAT  = 2;
  localparam int OPT_SECOND_FLOAT = 1;
  localparam int OPT_TONE_PIN_SEL = 0;
  localparam int DIR_FOURTH       = 2;
  localparam int DIR_THIRD        = 1;
  localparam int DIR_AND_COMBINE  = 0;
  localparam int TONE_COUNTER_EN  = 3;
  localparam int TONE_ENABLE      = 2;
  localparam int TONE_SEL_HI      = 1;
  localparam int TONE_SEL_LO      = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_NIBBLE = 4'h0;

  // ---------------------------------------------------------------
  // Tone selections and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] TONE_SILENT = 2'h0;
  localparam logic [1:0] TONE_1024   = 2'h1;
  localparam logic [1:0] TONE_2048   = 2'h2;
  localparam logic [1:0] TONE_2667   = 2'h3;
  localparam int CLK_HZ        = 25000000;
  localparam int PRESC_HZ      = 32768;
  localparam int PRESC_CYCLES  = CLK_HZ / PRESC_HZ;
  localparam int HALF_1024     = PRESC_HZ / (2 * 1024);
  localparam int HALF_2048     = PRESC_HZ / (2 * 2048);
  localparam int HALF_2667     = PRESC_HZ / (2 * 2667) + 1;

  // ---------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: iop_tone.sv
// Square wave tone generator driven by the prescaler tick
`timescale 1ns/1ns
module iop_tone
  import iop_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       tick,
  input  wire logic [1:0] sel,
  output logic            tone
);

  typedef struct packed {
    logic [1:0] sel_q;
    logic [4:0] cnt;
    logic       level;
  } iop_tone_t;

  iop_tone_t r;
  iop_tone_t next_r;
  logic [4:0] half;

  always_comb begin
    case (sel)
      TONE_1024: half = 5'(HALF_1024);
      TONE_2048: half = 5'(HALF_2048);
      TONE_2667: half = 5'(HALF_2667);
      default:   half = 5'h1;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r       = r;
    next_r.sel_q = sel;
    if (sel != r.sel_q) begin
      next_r.cnt   = 5'h0;
      next_r.level = (sel != TONE_SILENT);
    end else if (sel == TONE_SILENT) begin
      next_r.cnt   = 5'h0;
      next_r.level = 1'b0;
    end else if (tick) begin
      if (r.cnt == half - 5'h1) begin
        next_r.cnt   = 5'h0;
        next_r.level = ~r.level;
      end else begin
        next_r.cnt = r.cnt + 5'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tone = r.level;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  tone_restart_a: assert property (@(posedge clock) disable iff (!resetn)
    (sel != r.sel_q) |=> (tone == ($past(sel) != TONE_SILENT)))
    else $error("tone did not follow new selection at once");

endmodule // iop_tone

// file: iop_ports.sv
// Ports C, D, E with tone takeover and AXI4-Lite register slave
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module iop_ports
  import iop_pkg::*;
#(
  parameter int CLOCK_HZ = CLK_HZ
)
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sleep_req,
  input  wire logic        first_port_irq,
  input  wire logic        serial_write_buffer,
  input  wire logic        swb_clock,
  input  wire logic        swb_data,
  input  wire logic [3:0]  second_port_out_in,
  input  wire logic [3:0]  second_port_oe_in,
  output logic [3:0]       second_port_out,
  output logic [3:0]       second_port_oe,
  input  wire logic [3:0]  third_port_in,
  output logic [3:0]       third_port_out,
  output logic [3:0]       third_port_oe,
  input  wire logic [3:0]  fourth_port_in,
  output logic [3:0]       fourth_port_out,
  output logic [3:0]       fourth_port_oe,
  input  wire logic [3:0]  fifth_port_in,
  output logic [3:0]       fifth_port_out,
  output logic [3:0]       fifth_port_oe,
  output logic             counter_enable,
  output logic             cpu_irq
);

  localparam int PCYC = CLOCK_HZ / PRESC_HZ;

  if (PCYC < 2 || PCYC > 65535) begin : g_check
    $error("clock rate cannot feed the 32 kHz prescaler");
  end

  typedef struct packed {
    logic [3:0]  pc_s1;
    logic [3:0]  pc_s2;
    logic [3:0]  pc_prev;
    logic [3:0]  pd_s1;
    logic [3:0]  pd_s2;
    logic [3:0]  pe_s1;
    logic [3:0]  pe_s2;
    logic        sl_s1;
    logic        sl_s2;
    logic [3:0]  pc_data;
    logic [3:0]  pc_flags;
    logic [3:0]  pc_mask;
    logic [3:0]  option;
    logic [3:0]  pd_data;
    logic [3:0]  dir_comb;
    logic [3:0]  pe_data;
    logic [3:0]  pe_dir;
    logic [3:0]  tone_ctrl;
    logic [15:0] presc;
    logic        tick;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic        w_lane0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  b_out;
    logic [3:0]  b_oe;
    logic [3:0]  c_out;
    logic [3:0]  c_oe;
    logic [3:0]  d_out;
    logic [3:0]  d_oe;
    logic [3:0]  e_out;
    logic [3:0]  e_oe;
    logic        irq;
  } iop_state_t;

  iop_state_t r;
  iop_state_t next_r;
  logic       tone;
  logic [3:0] pc_rise;
  logic       pc_pending;
  logic       rd_flags;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= OFS_SUMMARY;
  endfunction

  function automatic logic [3:0] read_reg(input iop_state_t s,
                                          input logic [7:0] a);
    logic [3:0] v;
    v = 4'h0;
    case (a)
      OFS_PC_DATA:   v = s.dir_comb[DIR_THIRD] ? s.pc_data : s.pc_s2;
      OFS_PC_FLAGS:  v = s.pc_flags;
      OFS_PC_ENABLE: v = s.pc_mask;
      OFS_PD_DATA:   v = s.dir_comb[DIR_FOURTH] ? s.pd_data : s.pd_s2;
      OFS_DIR_COMB:  v = s.dir_comb;
      OFS_PE_DATA:   v = (s.pe_dir & s.pe_data) | (~s.pe_dir & s.pe_s2);
      OFS_PE_DIR:    v = s.pe_dir;
      OFS_TONE_CTRL: v = s.tone_ctrl;
      OFS_SUMMARY:   v = {3'h0, |s.pc_flags};
      default:       v = 4'h0;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Tone generator
  // ---------------------------------------------------------------
  iop_tone u_tone (
    .clock  (clock),
    .resetn (resetn),
    .tick   (r.tick),
    .sel    (r.tone_ctrl[TONE_SEL_HI:TONE_SEL_LO]),
    .tone   (tone)
  );

  assign pc_rise = r.pc_s2 & ~r.pc_prev & r.pc_mask
                 & ~{4{r.dir_comb[DIR_THIRD]}};
  assign pc_pending = |r.pc_flags;
  assign rd_flags = s_axi_arvalid && r.arready
                  && s_axi_araddr == OFS_PC_FLAGS;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic wr, fl_b, fl_c, fl_d, tone_on;
    wr      = 1'b0;
    fl_b    = 1'b0;
    fl_c    = 1'b0;
    fl_d    = 1'b0;
    tone_on = 1'b0;
    next_r  = r;

    // Pin synchronisers
    next_r.pc_s1   = third_port_in;
    next_r.pc_s2   = r.pc_s1;
    next_r.pc_prev = r.pc_s2;
    next_r.pd_s1   = fourth_port_in;
    next_r.pd_s2   = r.pd_s1;
    next_r.pe_s1   = fifth_port_in;
    next_r.pe_s2   = r.pe_s1;
    next_r.sl_s1   = sleep_req;
    next_r.sl_s2   = r.sl_s1;

    // Prescaler tick
    next_r.tick = 1'b0;
    if (r.presc == 16'(PCYC - 1)) begin
      next_r.presc = 16'h0;
      next_r.tick  = 1'b1;
    end else begin
      next_r.presc = r.presc + 16'h1;
    end

    // Interrupt flags: set wins over read clear
    next_r.pc_flags = (rd_flags ? 4'h0 : r.pc_flags) | pc_rise;

    // Write channel
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_held  = 1'b1;
      next_r.w_data  = s_axi_wdata;
      next_r.w_lane0 = s_axi_wstrb[0];
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      wr             = r.w_lane0 && is_mapped(r.aw_addr);
      next_r.aw_held = 1'b0;
      next_r.w_held  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = is_mapped(r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr) begin
      case (r.aw_addr)
        OFS_PC_DATA:   next_r.pc_data   = r.w_data[3:0];
        OFS_PC_ENABLE: next_r.pc_mask   = r.w_data[3:0];
        OFS_OPTION:    next_r.option    = r.w_data[3:0];
        OFS_PD_DATA:   next_r.pd_data   = r.w_data[3:0];
        OFS_DIR_COMB:  next_r.dir_comb  = r.w_data[3:0];
        OFS_PE_DATA:   next_r.pe_data   = r.w_data[3:0];
        OFS_PE_DIR:    next_r.pe_dir    = r.w_data[3:0];
        OFS_TONE_CTRL: next_r.tone_ctrl = r.w_data[3:0];
        default:       next_r.pc_mask   = next_r.pc_mask;
      endcase
    end
    next_r.awready = !next_r.aw_held && !next_r.bvalid;
    next_r.wready  = !next_r.w_held && !next_r.bvalid;

    // Read channel
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid  = 1'b0;
      next_r.arready = 1'b1;
    end
    if (s_axi_arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid  = 1'b1;
      next_r.rdata   = {28'h0, read_reg(r, s_axi_araddr)};
      next_r.rresp   = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end

    // Pin drivers
    fl_b    = r.sl_s2 && r.option[OPT_SECOND_FLOAT];
    fl_c    = r.sl_s2 && r.option[OPT_THIRD_FLOAT];
    fl_d    = r.sl_s2 && r.option[OPT_FOURTH_FLOAT];
    tone_on = r.tone_ctrl[TONE_ENABLE];

    next_r.c_out = r.pc_data;
    next_r.c_oe  = {4{r.dir_comb[DIR_THIRD] && !fl_c}};

    next_r.d_out = r.pd_data;
    next_r.d_oe  = {4{r.dir_comb[DIR_FOURTH]}};
    if (serial_write_buffer) begin
      next_r.d_out[1:0] = {swb_data, swb_clock};
      next_r.d_oe[1:0]  = 2'h3;
    end
    if (fl_d) begin
      next_r.d_oe = 4'h0;
    end

    next_r.b_out = second_port_out_in;
    next_r.b_oe  = second_port_oe_in;
    next_r.e_out = r.pe_data;
    next_r.e_oe  = r.pe_dir;
    if (tone_on && !r.option[OPT_TONE_PIN_SEL]) begin
      next_r.b_out[0] = tone;
      next_r.b_oe[0]  = 1'b1;
    end
    if (tone_on && r.option[OPT_TONE_PIN_SEL]) begin
      next_r.e_out[0] = tone;
      next_r.e_oe[0]  = 1'b1;
    end
    if (fl_b) begin
      next_r.b_oe = 4'h0;
    end

    // Request to the processor
    if (r.dir_comb[DIR_AND_COMBINE]) begin
      next_r.irq = first_port_irq && pc_pending;
    end else begin
      next_r.irq = first_port_irq || pc_pending;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      r         <= '0;
      r.arready <= 1'b1;
      r.awready <= 1'b1;
      r.wready  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready   = r.awready;
  assign s_axi_wready    = r.wready;
  assign s_axi_bvalid    = r.bvalid;
  assign s_axi_bresp     = r.bresp;
  assign s_axi_arready   = r.arready;
  assign s_axi_rvalid    = r.rvalid;
  assign s_axi_rdata     = r.rdata;
  assign s_axi_rresp     = r.rresp;
  assign second_port_out = r.b_out;
  assign second_port_oe  = r.b_oe;
  assign third_port_out  = r.c_out;
  assign third_port_oe   = r.c_oe;
  assign fourth_port_out = r.d_out;
  assign fourth_port_oe  = r.d_oe;
  assign fifth_port_out  = r.e_out;
  assign fifth_port_oe   = r.e_oe;
  assign counter_enable  = r.tone_ctrl[TONE_COUNTER_EN];
  assign cpu_irq         = r.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  c_float_a: assert property (@(posedge clock) disable iff (!resetn)
    (r.sl_s2 && r.option[OPT_THIRD_FLOAT]) |=> (third_port_oe == 4'h0))
    else $error("port C drove pins while asleep with float set");

  d_float_a: assert property (@(posedge clock) disable iff (!resetn)
    (r.sl_s2 && r.option[OPT_FOURTH_FLOAT]) |=> (fourth_port_oe == 4'h0))
    else $error("port D drove pins while asleep with float set");

  swb_pins_a: assert property (@(posedge clock) disable iff (!resetn)
    serial_write_buffer |=> (fourth_port_out[1:0] ==
                             {$past(swb_data), $past(swb_clock)}))
    else $error("serial buffer signals missing on port D");

  flag_clear_a: assert property (@(posedge clock) disable iff (!resetn)
    (rd_flags && pc_rise == 4'h0)
    |=> (r.pc_flags == 4'h0 && s_axi_rvalid))
    else $error("reading port C flags did not clear them");

  mask_gate_a: assert property (@(posedge clock) disable iff (!resetn)
    (r.pc_mask == 4'h0) |=> ((r.pc_flags & ~$past(r.pc_flags)) == 4'h0))
    else $error("masked port C pin raised a flag");

  combine_a: assert property (@(posedge clock) disable iff (!resetn)
    1'b1 |=> (cpu_irq == ($past(r.dir_comb[DIR_AND_COMBINE])
              ? ($past(first_port_irq) && $past(pc_pending))
              : ($past(first_port_irq) || $past(pc_pending)))))
    else $error("processor request does not match combine mode");

  b0_tone_a: assert property (@(posedge clock) disable iff (!resetn)
    (r.tone_ctrl[TONE_ENABLE] && !r.option[OPT_TONE_PIN_SEL] && !r.sl_s2)
    |=> (second_port_oe[0] && second_port_out[0] == $past(tone)))
    else $error("tone not on port B pin 0");

  e0_dir_a: assert property (@(posedge clock) disable iff (!resetn)
    !(r.tone_ctrl[TONE_ENABLE] && r.option[OPT_TONE_PIN_SEL])
    |=> (fifth_port_oe[0] == $past(r.pe_dir[0])))
    else $error("port E pin 0 ignores its direction bit");

  reset_vals_a: assert property (@(posedge clock)
    !resetn |=> (r.pe_dir == RST_NIBBLE && r.pc_mask == RST_NIBBLE
                 && r.pd_data == RST_NIBBLE && r.tone_ctrl == RST_NIBBLE))
    else $error("register not at its reset value");

  irq_set_c: cover property (@(posedge clock) disable iff (!resetn)
    (pc_rise != 4'h0) ##1 cpu_irq);

  tone_e0_c: cover property (@(posedge clock) disable iff (!resetn)
    fifth_port_oe[0] && r.tone_ctrl[TONE_ENABLE]
    && r.option[OPT_TONE_PIN_SEL]);

  swb_c: cover property (@(posedge clock) disable iff (!resetn)
    serial_write_buffer && fourth_port_oe[1:0] == 2'h3);

endmodule // iop_ports

// file: iop_pins.sv
// Board-side pin model for ports C, D and E
`timescale 1ns/1ns
module iop_pins
(
  input  wire logic [3:0] third_port_out,
  input  wire logic [3:0] third_port_oe,
  input  wire logic [3:0] fourth_port_out,
  input  wire logic [3:0] fourth_port_oe,
  input  wire logic [3:0] fifth_port_out,
  input  wire logic [3:0] fifth_port_oe,
  input  wire logic [3:0] c_ext,
  input  wire logic [3:0] d_ext,
  input  wire logic [3:0] e_ext,
  output logic      [3:0] third_port_in,
  output logic      [3:0] fourth_port_in,
  output logic      [3:0] fifth_port_in
);
  // ---------------------------------------------------------------
  // Pin level: device drive wins, else board level
  // ---------------------------------------------------------------
  assign third_port_in  = (third_port_oe & third_port_out)
                        | (~third_port_oe & c_ext);
  assign fourth_port_in = (fourth_port_oe & fourth_port_out)
                        | (~fourth_port_oe & d_ext);
  assign fifth_port_in  = (fifth_port_oe & fifth_port_out)
                        | (~fifth_port_oe & e_ext);
endmodule // iop_pins

// file: io_ports_cde_with_buzzer_test.sv
// Self-checking bench for ports C, D, E and tone takeover
`timescale 1ns/1ns
module io_ports_cde_with_buzzer_test
  import iop_pkg::*;
;
  localparam int SIM_HZ = 65536;
  localparam int TPC = SIM_HZ / PRESC_HZ;
  localparam logic [7:0] RW_OFS [4] = '{OFS_PC_ENABLE, OFS_DIR_COMB,
                                       OFS_PE_DIR, OFS_TONE_CTRL};
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic        clock, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_req;
  logic        first_port_irq, serial_write_buffer, swb_clock, swb_data;
  logic        counter_enable, cpu_irq, sel_e, tone_pin;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0]  s_axi_wstrb, second_port_out_in, second_port_oe_in, e_ext;
  logic [3:0]  second_port_out, second_port_oe, third_port_in, d_ext;
  logic [3:0]  third_port_out, third_port_oe, fourth_port_in, c_ext;
  logic [3:0]  fourth_port_out, fourth_port_oe, fifth_port_in;
  logic [3:0]  fifth_port_out, fifth_port_oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          mismatches, cmp_count, i;

  iop_ports #(.CLOCK_HZ(SIM_HZ)) DUT (.*);
  iop_pins pins (.*);
  assign tone_pin = sel_e ? fifth_port_out[0] : second_port_out[0];
  // ---------------------------------------------------------------
  // Expectations, compares and bus cycles
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic int half(input int sel);
    return TPC * (sel == 1 ? HALF_1024 : sel == 2 ? HALF_2048 : HALF_2667);
  endfunction
  function automatic logic [3:0] mix(input logic [3:0] dir, drv, ext);
    return (dir & drv) | (~dir & ext);
  endfunction
  task automatic results;
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 40) begin
      mismatches++;
      results();
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {28'h0000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 40 && s_axi_bvalid !== 1'b1; n++) begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    bound(n);
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] ed,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 40 && s_axi_rvalid !== 1'b1; n++) begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    bound(n);
    chk(s_axi_rdata, {28'h0000000, ed});
    chk(s_axi_rresp, er);
  endtask
  task automatic period(input int exp);
    int n, k;
    logic v;
    @(posedge clock);
    v = tone_pin;
    for (n = 0; n < 40 && tone_pin === v; n++) @(posedge clock);
    bound(n);
    for (int j = 0; j < 2; j++) begin
      v = tone_pin;
      for (k = 0; k < 40 && tone_pin === v; k++) @(posedge clock);
      bound(k);
      chk(k, exp);
    end
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
     s_axi_rready, sleep_req, first_port_irq, serial_write_buffer,
     swb_clock, swb_data, sel_e} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, second_port_out_in,
     second_port_oe_in, c_ext, d_ext, e_ext} = '0;
    s_axi_wstrb = 4'hF;
    seed = 32'h000107A2;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    settle(0);
    chk({third_port_oe, fourth_port_oe, fifth_port_oe, cpu_irq}, 0);
    for (i = 0; i < 10; i++) begin
      rd(8'(i * 4), 4'h0);
    end
    wr(8'h2C, 4'hF, RESP_SLVERR);
    rd(8'h02, 4'h0, RESP_SLVERR);
    wr(OFS_OPTION, 4'hE);
    rd(OFS_OPTION, 4'h0);
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(RW_OFS[i % 4], seed[3:0]);
      rd(RW_OFS[i % 4], seed[3:0]);
    end
    wr(OFS_TONE_CTRL, 4'h8);
    settle(2);
    chk(counter_enable, 1'b1);
    // Outputs, then inputs
    seed = xs(seed);
    wr(OFS_PC_ENABLE, 4'h0);
    wr(OFS_DIR_COMB, 4'h6);
    wr(OFS_PC_DATA, seed[3:0]);
    wr(OFS_PD_DATA, seed[7:4]);
    wr(OFS_PE_DIR, seed[11:8]);
    wr(OFS_PE_DATA, seed[15:12]);
    @(posedge clock);
    {c_ext, d_ext, e_ext} <= seed[27:16];
    second_port_oe_in <= 4'hF;
    settle(3);
    chk({third_port_oe, third_port_out}, {4'hF, seed[3:0]});
    chk({fourth_port_oe, fourth_port_out}, {4'hF, seed[7:4]});
    chk(fifth_port_oe, seed[11:8]);
    chk(fifth_port_out & seed[11:8], seed[15:12] & seed[11:8]);
    rd(OFS_PC_DATA, seed[3:0]);
    rd(OFS_PE_DATA, mix(seed[11:8], seed[15:12], seed[19:16]));
    // Sleep floating per option bit
    @(posedge clock);
    sleep_req <= 1'b1;
    for (i = 0; i < 8; i++) begin
      wr(OFS_OPTION, 4'(i * 2));
      settle(4);
      chk(third_port_oe, i[1] ? 4'h0 : 4'hF);
      chk(fourth_port_oe, i[2] ? 4'h0 : 4'hF);
      chk(second_port_oe, i[0] ? 4'h0 : 4'hF);
    end
    @(posedge clock);
    sleep_req <= 1'b0;
    serial_write_buffer <= 1'b1;
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      {swb_data, swb_clock} <= 2'(i);
      settle(3);
      chk(fourth_port_out, {seed[7:6], 2'(i)});
    end
    wr(OFS_OPTION, 4'h0);
    wr(OFS_DIR_COMB, 4'h0);
    settle(3);
    chk(third_port_oe, 4'h0);
    rd(OFS_PC_DATA, seed[27:24]);
    // Serial buffer still owns D0/D1 here
    rd(OFS_PD_DATA, {seed[23:22], 2'h3});
    // Pin interrupt flags and request combining
    @(posedge clock);
    serial_write_buffer <= 1'b0;
    c_ext <= 4'h0;
    wr(OFS_PC_ENABLE, 4'hB);
    settle(3);
    @(posedge clock);
    c_ext <= 4'h7;
    settle(5);
    chk(cpu_irq, 1'b1);
    wr(OFS_DIR_COMB, 4'h1);
    settle(2);
    chk(cpu_irq, 1'b0);
    @(posedge clock);
    first_port_irq <= 1'b1;
    settle(3);
    chk(cpu_irq, 1'b1);
    @(posedge clock);
    first_port_irq <= 1'b0;
    wr(OFS_DIR_COMB, 4'h0);
    rd(OFS_SUMMARY, 4'h1);
    rd(OFS_PC_FLAGS, 4'h3);
    rd(OFS_PC_FLAGS, 4'h0);
    rd(OFS_SUMMARY, 4'h0);
    settle(2);
    chk(cpu_irq, 1'b0);
    // Tone on port B pin 0, then port E pin 0
    @(posedge clock);
    second_port_oe_in <= 4'h2;
    second_port_out_in <= 4'h5;
    for (i = 1; i < 4; i++) begin
      wr(OFS_TONE_CTRL, 4'(4 + i));
      settle(3);
      chk({second_port_oe[0], tone_pin}, 2'h3);
      period(half(i));
    end
    wr(OFS_TONE_CTRL, 4'h4);
    settle(3);
    chk({second_port_oe[0], second_port_out[0]}, 2'h2);
    wr(OFS_TONE_CTRL, 4'h5);
    wr(OFS_OPTION, 4'h1);
    @(posedge clock);
    sel_e <= 1'b1;
    settle(3);
    chk({fifth_port_oe[0], second_port_oe[0], second_port_out[0]}, 3'h5);
    period(half(1));
    wr(OFS_TONE_CTRL, 4'h0);
    settle(3);
    chk({second_port_oe, second_port_out}, 8'h25);
    chk(fifth_port_oe, seed[11:8]);
    results();
  end
endmodule // io_ports_cde_with_buzzer_test
